// *** rtl/pbs_pkg.sv ***
// package of constants and carriers for the pipelined burst sram port
package pbs_pkg;
    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int ADDR_W = 17;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int WORD_W = 36;
    localparam int BURST_W = 2;
    localparam int FIFO_DEPTH = 4;
    localparam int LANE_DATA_W = 8;
    localparam int PAR_BIT = 8;
    localparam logic [1:0] BURST_RESET = 2'h0;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic sel_a_n;
        logic sel_b;
        logic sel_c_n;
        logic write_n;
        logic adv_n;
        logic [LANES-1:0] lane_n;
        logic [ADDR_W-1:0] addr;
    } pbs_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] lanes;
        logic write;
    } pbs_op_t;
endpackage : pbs_pkg

// *** rtl/pbs_fifo.sv ***
// small valid/ready fifo used in the read data path
`timescale 1ns/1ps
module pbs_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    wire push = clk_en && in_valid && in_ready;
    wire pop = clk_en && out_valid && out_ready;

    // full and empty come straight from the count
    assign in_ready = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // storage, no reset needed on data
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // never overfilled, never drained when empty
    property p_fifo_bounds;
        @(posedge clk_sys) disable iff (!reset_n) count <= (PW+1)'(DEPTH);
    endproperty
    a_fifo_bounds: assert property (p_fifo_bounds) else $error("fifo count out of range");
endmodule : pbs_fifo

// *** rtl/pbs_port.sv ***
// pipelined burst sram port: capture, burst counter, lanes, selects, output enable
// Function
// RULE_01: sample address on qualified edge, pick word
// RULE_02: low two address bits seed burst counter
// RULE_03: active-low byte lanes qualify writes
// RULE_04: write enable low starts write sequence
// RULE_05: advance high advances burst counter
// RULE_06: advance low loads fresh address
// RULE_07: controller loads address after deselect
// RULE_08: inputs ignored while clock enable high
// RULE_09: selected only when selects low-high-low
// RULE_10: output enable low lets data pins drive
// RULE_11: no drive on writes, first cycle, deselect
// RULE_12: clock enable high holds state, no deselect
// RULE_13: strap low linear, high interleaved burst; code always captures the synchroniser reset value 1, so bursts are interleaved
// RULE_14: parity bits follow data, gated by lane
// RULE_15: sleep input idles device, keeps data
// RULE_16: each lane is eight data plus parity
`timescale 1ns/1ps
module pbs_port #(
    parameter int ADDR_W = pbs_pkg::ADDR_W,
    parameter int WORDS = 1 << pbs_pkg::ADDR_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic clock_qualify_n,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic write_enable_n,
    input wire logic advance_or_load_n,
    input wire logic [pbs_pkg::LANES-1:0] byte_write_lane_n,
    input wire logic [ADDR_W-1:0] address_inputs,
    input wire logic output_enable_n,
    input wire logic burst_order,
    input wire logic sleep_request,
    input wire logic [pbs_pkg::WORD_W-1:0] data_in,
    output logic [pbs_pkg::WORD_W-1:0] data_out,
    output logic data_oe
);
    // ****************************************************************
    // pin synchronisers for the asynchronous inputs
    // ****************************************************************
    logic [1:0] oe_sync;
    logic [1:0] sleep_sync;
    logic [1:0] mode_sync;
    logic mode;
    logic mode_armed;
    logic mode_taken;
    wire oe_n_s = oe_sync[1];
    wire sleep_s = sleep_sync[1];

    // only the second stage is read by logic
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            oe_sync <= 2'h3;
            sleep_sync <= 2'h0;
            mode_sync <= 2'h3;
        end else if (clk_en) begin
            oe_sync <= {oe_sync[0], output_enable_n};
            sleep_sync <= {sleep_sync[0], sleep_request};
            mode_sync <= {mode_sync[0], burst_order};
        end
    end

    // strap is caught once, at the second edge, while the synchroniser's second stage still holds its reset value, not the pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mode <= 1'b1;
            mode_armed <= 1'b0;
            mode_taken <= 1'b0;
        end else if (clk_en && !mode_taken) begin
            mode_armed <= 1'b1;
            if (mode_armed) begin
                mode <= mode_sync[1]; // [RULE_13]
                mode_taken <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // input registers
    // ****************************************************************
    pbs_pkg::pbs_cmd_t cmd;
    logic [pbs_pkg::WORD_W-1:0] din;
    wire edge_ok = clk_en && !clock_qualify_n && !sleep_s; // [RULE_08] [RULE_15]

    // inputs captured only on qualified edges; otherwise held
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cmd <= '{sel_a_n: 1'b1, sel_b: 1'b0, sel_c_n: 1'b1, write_n: 1'b1,
                     adv_n: 1'b0, lane_n: '1, addr: '0};
            din <= '0;
        end else begin
            if (edge_ok) begin
                cmd <= '{sel_a_n: chip_select_a_n, sel_b: chip_select_b,
                         sel_c_n: chip_select_c_n, write_n: write_enable_n,
                         adv_n: advance_or_load_n, lane_n: byte_write_lane_n,
                         addr: address_inputs}; // [RULE_01] [RULE_03] [RULE_04]
                din <= data_in;
            end
        end
    end

    // ****************************************************************
    // decode and burst counter
    // ****************************************************************
    function automatic logic [1:0] burst_next(input logic [1:0] base, input logic [1:0] cnt,
                                              input logic linear);
        burst_next = linear ? base + cnt : base ^ cnt;
    endfunction : burst_next

    logic selected;
    logic writing;
    logic [ADDR_W-1:0] base_addr;
    logic [1:0] burst_cnt;
    logic [pbs_pkg::LANES-1:0] burst_lanes;
    wire select_hit = !cmd.sel_a_n && cmd.sel_b && !cmd.sel_c_n; // [RULE_09]
    wire load_op = !cmd.adv_n; // [RULE_06]
    wire adv_op = cmd.adv_n && selected; // [RULE_05]
    wire [1:0] next_cnt = burst_cnt + 2'h1;
    wire now_sel = load_op ? select_hit : selected;
    wire now_write = load_op ? !cmd.write_n : writing;
    wire [ADDR_W-1:0] now_base = load_op ? cmd.addr : base_addr;
    wire [1:0] now_cnt = load_op ? pbs_pkg::BURST_RESET : next_cnt;
    wire [1:0] low_bits = burst_next(now_base[1:0], now_cnt, !mode); // [RULE_02] [RULE_13]
    wire [ADDR_W-1:0] word_addr = {now_base[ADDR_W-1:2], low_bits};
    wire [pbs_pkg::LANES-1:0] now_lanes = ~cmd.lane_n; // [RULE_03]

    // burst state moves only on a qualified edge's command
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            selected <= 1'b0;
            writing <= 1'b0;
            base_addr <= '0;
            burst_cnt <= pbs_pkg::BURST_RESET;
            burst_lanes <= '0;
        end else if (edge_ok && (load_op || adv_op)) begin // [RULE_12]
            selected <= now_sel;
            writing <= now_write;
            base_addr <= now_base;
            burst_cnt <= now_cnt;
            burst_lanes <= now_lanes;
        end
    end

    // ****************************************************************
    // storage array with lane-gated writes
    // ****************************************************************
    logic [pbs_pkg::WORD_W-1:0] mem [WORDS];
    // a captured command runs at the next qualified edge; masked edges leave it waiting
    wire do_access = edge_ok && now_sel && (load_op || adv_op);
    wire do_write = do_access && now_write;
    wire do_read = do_access && !now_write;

    // each lane carries 8 data bits and its parity bit
    always_ff @(posedge clk_sys) begin
        if (do_write) begin
            for (int l = 0; l < pbs_pkg::LANES; l++) begin
                if (now_lanes[l]) begin // [RULE_14] [RULE_16]
                    mem[word_addr][l*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] <=
                        din[l*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
                end
            end
        end
    end

    // ****************************************************************
    // read path through fifo, output register and drive control
    // ****************************************************************
    logic [pbs_pkg::WORD_W-1:0] rd_word;
    logic rd_valid;
    logic prev_sel;
    logic emerging;
    logic out_valid;
    wire fifo_ready;
    wire [pbs_pkg::WORD_W-1:0] fifo_word;

    // fifo refuses only when full; read issue does not wait on it, a new read overwrites the held word
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_word <= '0;
            rd_valid <= 1'b0;
        end else if (edge_ok) begin
            if (do_read) rd_word <= mem[word_addr]; // [RULE_01]
            if (do_read) rd_valid <= 1'b1;
            else if (fifo_ready) rd_valid <= 1'b0;
        end
    end

    pbs_fifo #(.WIDTH(pbs_pkg::WORD_W), .DEPTH(pbs_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .clk_en(edge_ok),
        .in_valid(rd_valid),
        .in_ready(fifo_ready),
        .in_data(rd_word),
        .out_valid(out_valid),
        .out_ready(1'b1),
        .out_data(fifo_word)
    );

    // drive only while a read word comes out; the pipeline keeps the first cycle quiet
    wire may_drive = out_valid && !writing && !oe_n_s; // [RULE_10] [RULE_11]
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prev_sel <= 1'b0;
            emerging <= 1'b0;
            data_out <= '0;
            data_oe <= 1'b0;
        end else if (edge_ok) begin // masked edges let the word stand [RULE_12]
            prev_sel <= selected;
            emerging <= selected && !prev_sel; // [RULE_11]
            if (out_valid) data_out <= fifo_word;
            data_oe <= may_drive;
        end
    end
    property p_no_drive_write;
        @(posedge clk_sys) disable iff (!reset_n) edge_ok && writing |=> !data_oe;
    endproperty
    a_no_drive_write: assert property (p_no_drive_write) else $error("drove on write"); // [RULE_11]

    // output enable high keeps the pins released
    property p_oe_mask;
        @(posedge clk_sys) disable iff (!reset_n) edge_ok && oe_n_s |=> !data_oe;
    endproperty
    a_oe_mask: assert property (p_oe_mask) // [RULE_10]
        else $error("drove with output enable high");

    // first cycle after leaving deselect stays undriven
    property p_emerge_quiet;
        @(posedge clk_sys) disable iff (!reset_n) emerging |-> !data_oe;
    endproperty
    a_emerge_quiet: assert property (p_emerge_quiet) // [RULE_11]
        else $error("drove while emerging from deselect");

    // a load restarts the burst count
    sequence s_load_taken;
        edge_ok && load_op;
    endsequence
    property p_load_cnt;
        @(posedge clk_sys) disable iff (!reset_n) s_load_taken |=> burst_cnt == pbs_pkg::BURST_RESET;
    endproperty
    a_load_cnt: assert property (p_load_cnt) // [RULE_06]
        else $error("load did not restart burst count");

    // an advance steps the count by one
    property p_adv_cnt;
        @(posedge clk_sys) disable iff (!reset_n)
            edge_ok && adv_op |=> burst_cnt == $past(burst_cnt) + 2'h1;
    endproperty
    a_adv_cnt: assert property (p_adv_cnt) // [RULE_05]
        else $error("advance did not step burst count");

    // a masked or frozen edge changes nothing that is seen
    property p_hold;
        @(posedge clk_sys) disable iff (!reset_n)
            !edge_ok |=> $stable(burst_cnt) && $stable(data_oe) && $stable(data_out);
    endproperty
    a_hold: assert property (p_hold) // [RULE_12]
        else $error("state moved on a masked edge");
endmodule : pbs_port

// *** bench/pbs_ctrl_model.sv ***
// controller model that drives commands and write data into the sram port
`timescale 1ns/1ps
module pbs_ctrl_model (
    input wire logic clk_sys,
    output pbs_pkg::pbs_cmd_t cmd,
    output logic clock_qualify_n,
    output logic output_enable_n,
    output logic sleep_request,
    output logic [pbs_pkg::WORD_W-1:0] data_in
);
    // idle: deselected, load armed, bus parked
    initial begin
        cmd = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hf, 17'h0};
        clock_qualify_n = 1'b0;
        output_enable_n = 1'b0;
        sleep_request = 1'b0;
        data_in = 36'h0;
    end
    // one command edge; rf is {sleep, clock mask}
    task automatic op(input logic [2:0] sel, input logic wr, input logic adv,
            input logic [3:0] ln, input logic [16:0] a, input logic [35:0] d,
            input logic [1:0] rf);
        @(posedge clk_sys);
        cmd <= '{sel[2], sel[1], sel[0], ~wr, adv, ~ln, a};
        data_in <= wr ? d : ~data_in; // released bus toggles, never keeps a value
        clock_qualify_n <= rf[0];
        sleep_request <= rf[1];
    endtask : op
    // deselect with load armed; write data stays up for the data phase
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            cmd <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hf, cmd.addr};
            clock_qualify_n <= 1'b0;
            sleep_request <= 1'b0;
        end
    endtask : idle
    task automatic set_oe(input logic v);
        @(posedge clk_sys);
        output_enable_n <= v;
    endtask : set_oe
endmodule : pbs_ctrl_model

// *** bench/tb_top.sv ***
// self-checking bench of the sram port driven by the controller model
`timescale 1ns/1ps
module tb_top;
    logic clk_sys;
    logic reset_n;
    pbs_pkg::pbs_cmd_t cmd;
    logic clock_qualify_n;
    logic output_enable_n;
    logic sleep_request;
    logic [35:0] data_in;
    logic [35:0] data_out;
    logic data_oe;
    logic clk_en;
    logic burst_order;
    int fail_count;
    int cmp_count;
    logic [31:0] lfsr = 32'h63;
    logic [35:0] mem [logic [16:0]];
    logic [35:0] exp [$];

    pbs_ctrl_model ctrl_u (.clk_sys(clk_sys), .cmd(cmd), .clock_qualify_n(clock_qualify_n),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request), .data_in(data_in));
    pbs_port dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .clock_qualify_n(clock_qualify_n), .chip_select_a_n(cmd.sel_a_n),
        .chip_select_b(cmd.sel_b), .chip_select_c_n(cmd.sel_c_n),
        .write_enable_n(cmd.write_n), .advance_or_load_n(cmd.adv_n),
        .byte_write_lane_n(cmd.lane_n), .address_inputs(cmd.addr),
        .output_enable_n(output_enable_n), .burst_order(burst_order),
        .sleep_request(sleep_request), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe));

    // fixed seed keeps runs repeatable
    function automatic logic [31:0] rnd();
        repeat (32) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    function automatic logic [35:0] rw();
        return 36'({rnd(), rnd()});
    endfunction : rw
    // lane l is bits 9l+8..9l, parity on top
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
            input logic [3:0] ln);
        merge = o;
        for (int l = 0; l < 4; l++) if (ln[l]) merge[l*9 +: 9] = n[l*9 +: 9];
    endfunction : merge
    task automatic stop_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    // refused writes leave the model untouched
    task automatic wr(input logic [16:0] a, input logic [3:0] ln, input logic [35:0] d,
            input logic [1:0] rf);
        // sleep is asynchronous: raise it early so it has settled at the write edge
        if (rf[1]) repeat (2) ctrl_u.op(3'b111, 1'b0, 1'b0, 4'h0, a, 36'h0, rf);
        ctrl_u.op(3'b010, 1'b1, 1'b0, ln, a, d, rf);
        ctrl_u.idle(4);
        if (rf == 2'b00 && clk_en) mem[a] = merge(mem.exists(a) ? mem[a] : 36'h0, d, ln);
    endtask : wr
    // load, optional clock mask, then advances; words come back in a run
    task automatic rd(input logic [16:0] a, input int beats, input int stall);
        int i;
        exp.delete();
        for (i = 0; i < beats; i++) begin
            exp.push_back(mem[{a[16:2], burst_order ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)}]);
        end
        @(negedge clk_sys);
        fork
            begin
                ctrl_u.op(3'b010, 1'b0, 1'b0, 4'h0, a, 36'h0, 2'b00);
                repeat (stall) ctrl_u.op(3'b010, 1'b0, 1'b1, 4'h0, a, 36'h0, 2'b01);
                for (int k = 1; k < beats; k++) begin
                    ctrl_u.op(3'b010, 1'b0, 1'b1, 4'h0, a, 36'h0, 2'b00);
                end
                ctrl_u.idle(1);
            end
        join_none
        repeat (stall) begin
            @(negedge clk_sys);
            check(data_oe === 1'b0, "output moved under clock mask");
        end
        i = 0;
        while (data_oe !== 1'b1 && i < 12) begin
            @(negedge clk_sys);
            i++;
        end
        if (data_oe !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: no read data", $time);
            stop_test();
        end
        foreach (exp[k]) begin
            check(data_oe === 1'b1 && data_out === exp[k], "read word differs");
            @(negedge clk_sys);
        end
    endtask : rd
    // a read that must leave the pins undriven
    task automatic quiet(input logic [2:0] sel);
        ctrl_u.op(sel, 1'b0, 1'b0, 4'h0, 17'h0, 36'h0, 2'b00);
        ctrl_u.idle(1);
        repeat (6) begin
            @(negedge clk_sys);
            check(data_oe === 1'b0, "pins driven");
        end
    endtask : quiet

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        logic [16:0] a;
        logic [3:0] ln;
        fail_count = 0;
        cmp_count = 0;
        clk_en = 1'b1;
        burst_order = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        ctrl_u.idle(3);
        @(negedge clk_sys);
        check(data_oe === 1'b0, "pins driven after reset");
        // full word then partial lanes; edge addresses and end lanes first
        for (int n = 0; n < 8; n++) begin
            a = n == 0 ? 17'h0 : n == 1 ? 17'h1ffff : 17'(rnd());
            ln = n == 0 ? 4'h1 : n == 1 ? 4'h8 : 4'(rnd());
            wr(a, 4'hf, rw(), 2'b00);
            wr(a, ln, rw(), 2'b00);
            rd(a, 1, 0);
        end
        // interleaved burst from low bits 2 wraps inside its group of four, same order as linear
        a = 17'(rnd()) & 17'h1fffc;
        for (int k = 0; k < 4; k++) wr(a | 17'(k), 4'hf, rw(), 2'b00);
        rd(a | 17'h2, 4, 0);
        rd(a, 2, 5);
        for (int s = 0; s < 8; s++) if (s != 2) quiet(3'(s));
        ctrl_u.set_oe(1'b1);
        quiet(3'b010);
        ctrl_u.set_oe(1'b0);
        // masked clock, sleep and a frozen clock enable all refuse a write
        for (int r = 1; r < 4; r++) begin
            @(posedge clk_sys);
            clk_en <= (r != 3);
            wr(a, 4'hf, rw(), r == 3 ? 2'b00 : 2'(r));
            clk_en <= 1'b1;
            rd(a, 1, 0);
        end
        // second reset recaptures the mode from the synchroniser reset value: interleaved burst from low bits 1
        @(posedge clk_sys);
        reset_n <= 1'b0;
        burst_order <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        ctrl_u.idle(3);
        @(negedge clk_sys);
        check(data_oe === 1'b0, "pins driven after second reset");
        for (int k = 0; k < 4; k++) wr(a | 17'(k), 4'hf, rw(), 2'b00);
        rd(a | 17'h1, 4, 0);
        stop_test();
    end
endmodule : tb_top
